// [shared/pfs_pkg.sv]
// constants and types of the power-unit fault supervisor
// ---------------------------------------------------------------------------
// Summary of operation
// - a system-rail undervoltage shuts the whole unit down at once and holds it until the enable pin is low or the rail recovers.
// - a main-supply overvoltage shuts the unit down after 100 ms, and the overvoltage condition clears itself below the low threshold.
// - a converter current limit turns both switches off until the next switching cycle, and shuts the unit down if it persists 100 ms.
// - an overload present in every switching cycle for 100 ms shuts the unit down, and one clean cycle prevents it.
// - latched channel faults hold until a main-supply-domain power-on reset or the enable pin going low.
// - after soft-start a feedback undervoltage turns both switches of that channel off at once and latches.
// - the step-up channel also checks feedback undervoltage after pre-charge and turns its switches off at once.
// - the step-up output undervoltage counts only after soft-start and shuts the unit down after 100 ms.
// - a configuration bit picks the LED overvoltage threshold, low level when 0 and high level when 1.
// - an LED overvoltage turns off only the LED channel, leaving the others running.
// - the LED shutdown is released by power-on reset together with clearing the LED enable field, or by the enable pin low.
// - over-temperature stops switching on all channels at once until the die has cooled by the hysteresis.
// ---------------------------------------------------------------------------
package pfs_pkg;
    localparam int NCH = 5;
    localparam int BOOST_CH = 0;
    localparam int CLK_HZ = 40000000;
    localparam int FAULT_DELAY_MS = 100;
    localparam int FAULT_CYCLES = FAULT_DELAY_MS * (CLK_HZ / 1000);
    localparam int CNT_W = 22;
    // delay counter slots
    localparam int CNT_MAIN_OV = 0;
    localparam int CNT_CL0 = 1;
    localparam int CNT_OL0 = 1 + NCH;
    localparam int CNT_BOOST_UV = 1 + 2 * NCH;
    localparam int NCNT = 2 + 2 * NCH;
    // register byte offsets
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam logic [3:0] OFS_MASK = 4'h8;
    localparam logic [3:0] OFS_STATE = 4'hC;
    // control fields
    localparam int CTRL_LEVEL_BIT = 0;
    localparam int CTRL_LED_LSB = 8;
    localparam int LED_FIELD_W = 5;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] CTRL_WMASK = 32'h0000_1F01;
    // event bits of status and mask
    localparam int NEV = 6;
    localparam int EV_SYS_UV = 0;
    localparam int EV_MAIN_OV = 1;
    localparam int EV_UNIT_OFF = 2;
    localparam int EV_THERMAL = 3;
    localparam int EV_LED_OV = 4;
    localparam int EV_CH_UV = 5;
    localparam logic [NEV-1:0] EV_RESET = 6'h00;
    // comparator and pin flags as they arrive
    typedef struct packed {
        logic [NCH-1:0] ss_done;
        logic [NCH-1:0] fb_uv;
        logic [NCH-1:0] overload_flag;
        logic [NCH-1:0] cur_limit;
        logic led_ov_high;
        logic led_ov_low;
        logic boost_out_uv;
        logic precharge_done;
        logic cycle_tick;
        logic temp_cool;
        logic temp_hot;
        logic main_sense_low;
        logic main_sense_high;
        logic system_rail_ok;
        logic system_rail_uv;
        logic main_supply_domain_por;
        logic channel_group_enable_pin;
    } pfs_flags_t;
    localparam int FLAGS_W = $bits(pfs_flags_t);
endpackage : pfs_pkg

// [hdl/pfs_supervisor.sv]
// fault supervisor with wishbone register slave
//
// The address map and register access over Wishbone were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module pfs_supervisor #(
    parameter int FAULT_CYCLES = pfs_pkg::FAULT_CYCLES
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire pfs_pkg::pfs_flags_t flags_i,
    output logic unit_off_o,
    output logic [pfs_pkg::NCH-1:0] ch_off_o,
    output logic led_off_o,
    output logic stop_switching_o,
    output logic irq_o
);
    localparam int NCH = pfs_pkg::NCH;
    localparam int NCNT = pfs_pkg::NCNT;
    localparam int CW = pfs_pkg::CNT_W;
    localparam logic [CW-1:0] CNT_LAST = CW'(FAULT_CYCLES - 1);

    // byte-lane merge of a write
    function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction : lane_merge

    // ------------------------------------------------------------
    // input synchroniser
    // ------------------------------------------------------------
    logic [pfs_pkg::FLAGS_W-1:0] sync1_q;
    logic [pfs_pkg::FLAGS_W-1:0] sync2_q;
    pfs_pkg::pfs_flags_t fs;

    // two stages for every pin flag
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= flags_i;
            sync2_q <= sync1_q;
        end
    end
    assign fs = pfs_pkg::pfs_flags_t'(sync2_q);

    // ------------------------------------------------------------
    // state and next-state
    // ------------------------------------------------------------
    logic en_low;
    logic por;
    logic tick_q;
    logic tick_rise;
    logic sysuv_q, sysuv_d;
    logic ovm_q, ovm_d;
    logic unit_q, unit_d;
    logic therm_q, therm_d;
    logic led_q, led_d;
    logic led_hit;
    logic [NCH-1:0] blank_q, blank_d;
    logic [NCH-1:0] fbl_q, fbl_d;
    logic [NCH-1:0] fb_set;
    logic [NCH-1:0] ol_cur_q, ol_prev_q;
    logic [NCH-1:0] cl_cur_q, cl_prev_q;
    logic [NCNT-1:0] qual;
    logic [NCNT-1:0] done;
    logic [CW-1:0] cnt_q [NCNT];
    logic [31:0] ctrl_q, ctrl_d;
    logic [pfs_pkg::NEV-1:0] status_q, status_d, mask_q, mask_d, ev, w1c;
    logic [31:0] state_word;
    logic [31:0] rd_d;
    logic req, wr, hit_ctrl, hit_status, hit_mask, hit_state;
    logic level_sel;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    assign en_low = !fs.channel_group_enable_pin;
    assign por = fs.main_supply_domain_por;
    assign tick_rise = fs.cycle_tick && !tick_q;
    assign level_sel = ctrl_q[pfs_pkg::CTRL_LEVEL_BIT];

    // system rail undervoltage: set wins, released by enable low or recovery
    assign sysuv_d = fs.system_rail_uv ? 1'b1 : ((en_low || fs.system_rail_ok) ? 1'b0 : sysuv_q);
    // main overvoltage condition with self-clearing hysteresis
    assign ovm_d = fs.main_sense_high ? 1'b1 : (fs.main_sense_low ? 1'b0 : ovm_q);
    // unit shutdown latched when any delay expires
    assign unit_d = (|done) ? 1'b1 : ((por || en_low) ? 1'b0 : unit_q);
    // thermal stop with cool-down release
    assign therm_d = fs.temp_hot ? 1'b1 : (fs.temp_cool ? 1'b0 : therm_q);
    // led overvoltage threshold pick and channel-only latch
    assign led_hit = level_sel ? fs.led_ov_high : fs.led_ov_low;
    assign led_d = led_hit ? 1'b1 : ((por || en_low) ? 1'b0 : led_q);
    // current-limit blanking to the next switching cycle
    assign blank_d = fs.cur_limit | (tick_rise ? '0 : blank_q);

    // feedback undervoltage qualified by soft-start, plus boost pre-charge check
    always_comb begin
        fb_set = fs.fb_uv & fs.ss_done;
        fb_set[pfs_pkg::BOOST_CH] = fs.fb_uv[pfs_pkg::BOOST_CH]
            && (fs.ss_done[pfs_pkg::BOOST_CH] || fs.precharge_done);
    end
    assign fbl_d = fb_set | ((por || en_low) ? '0 : fbl_q);

    // qualifying conditions of the delay counters
    always_comb begin
        qual = '0;
        qual[pfs_pkg::CNT_MAIN_OV] = ovm_q;
        qual[pfs_pkg::CNT_CL0 +: NCH] = cl_prev_q;
        qual[pfs_pkg::CNT_OL0 +: NCH] = ol_prev_q;
        qual[pfs_pkg::CNT_BOOST_UV] = fs.boost_out_uv && fs.ss_done[pfs_pkg::BOOST_CH];
        for (int i = 0; i < NCNT; i++) begin
            done[i] = qual[i] && (cnt_q[i] == CNT_LAST);
        end
    end

    // ------------------------------------------------------------
    // fault state registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            tick_q <= 1'b0;
            sysuv_q <= 1'b0;
            ovm_q <= 1'b0;
            unit_q <= 1'b0;
            therm_q <= 1'b0;
            led_q <= 1'b0;
            blank_q <= '0;
            fbl_q <= '0;
        end else begin
            tick_q <= fs.cycle_tick;
            sysuv_q <= sysuv_d;
            ovm_q <= ovm_d;
            unit_q <= unit_d;
            therm_q <= therm_d;
            led_q <= led_d;
            blank_q <= blank_d;
            fbl_q <= fbl_d;
        end
    end

    // per-cycle presence of overload and current limit
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ol_cur_q <= '0;
            ol_prev_q <= '0;
            cl_cur_q <= '0;
            cl_prev_q <= '0;
        end else if (tick_rise) begin
            ol_prev_q <= ol_cur_q | fs.overload_flag;
            cl_prev_q <= cl_cur_q | fs.cur_limit;
            ol_cur_q <= '0;
            cl_cur_q <= '0;
        end else begin
            ol_cur_q <= ol_cur_q | fs.overload_flag;
            cl_cur_q <= cl_cur_q | fs.cur_limit;
        end
    end

    // 100 ms delay counters, cleared whenever the fault is absent
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < NCNT; i++) begin
                cnt_q[i] <= '0;
            end
        end else begin
            for (int i = 0; i < NCNT; i++) begin
                if (!qual[i]) begin
                    cnt_q[i] <= '0;
                end else if (cnt_q[i] != CNT_LAST) begin
                    cnt_q[i] <= cnt_q[i] + 1'b1;
                end
            end
        end
    end

    // registered control outputs
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            unit_off_o <= 1'b0;
            ch_off_o <= '0;
            led_off_o <= 1'b0;
            stop_switching_o <= 1'b0;
        end else begin
            unit_off_o <= unit_d || sysuv_d;
            ch_off_o <= blank_d | fbl_d | {NCH{unit_d || sysuv_d || therm_d}};
            led_off_o <= led_d || unit_d || sysuv_d || therm_d;
            stop_switching_o <= therm_d;
        end
    end

    // ------------------------------------------------------------
    // wishbone slave and interrupt
    // ------------------------------------------------------------
    assign req = wb_cyc_i && wb_stb_i;
    assign wr = req && wb_we_i && wb_ack_o;
    assign hit_ctrl = (wb_adr_i == pfs_pkg::OFS_CTRL);
    assign hit_status = (wb_adr_i == pfs_pkg::OFS_STATUS);
    assign hit_mask = (wb_adr_i == pfs_pkg::OFS_MASK);
    assign hit_state = (wb_adr_i == pfs_pkg::OFS_STATE);

    // fault events for the sticky status
    assign ev[pfs_pkg::EV_SYS_UV] = sysuv_d && !sysuv_q;
    assign ev[pfs_pkg::EV_MAIN_OV] = ovm_d && !ovm_q;
    assign ev[pfs_pkg::EV_UNIT_OFF] = unit_d && !unit_q;
    assign ev[pfs_pkg::EV_THERMAL] = therm_d && !therm_q;
    assign ev[pfs_pkg::EV_LED_OV] = led_d && !led_q;
    assign ev[pfs_pkg::EV_CH_UV] = |(fbl_d & ~fbl_q);

    // write-one-to-clear, a new event wins over the clear
    assign w1c = (wr && hit_status && wb_sel_i[0]) ? wb_dat_i[pfs_pkg::NEV-1:0] : '0;
    assign status_d = (status_q & ~w1c) | ev;
    assign mask_d = (wr && hit_mask && wb_sel_i[0]) ? wb_dat_i[pfs_pkg::NEV-1:0] : mask_q;

    // control write; power-on reset clears the led enable field
    always_comb begin
        ctrl_d = ctrl_q;
        if (wr && hit_ctrl) begin
            ctrl_d = lane_merge(ctrl_q, wb_dat_i, wb_sel_i) & pfs_pkg::CTRL_WMASK;
        end
        if (por) begin
            ctrl_d[pfs_pkg::CTRL_LED_LSB +: pfs_pkg::LED_FIELD_W] = '0;
        end
    end

    // live fault state readout
    assign state_word = {11'h000, ol_prev_q, cl_prev_q, fbl_q, blank_q[0], led_q, therm_q, unit_q, ovm_q, sysuv_q};
    assign rd_d = hit_ctrl ? ctrl_q
        : hit_status ? {26'h0000000, status_q}
        : hit_mask ? {26'h0000000, mask_q}
        : hit_state ? state_word
        : 32'h0000_0000;

    // one-wait-state ack; registers update at the acked edge
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            ctrl_q <= pfs_pkg::CTRL_RESET;
            status_q <= pfs_pkg::EV_RESET;
            mask_q <= pfs_pkg::EV_RESET;
        end else begin
            wb_ack_o <= req && !wb_ack_o;
            wb_dat_o <= rd_d;
            ctrl_q <= ctrl_d;
            status_q <= status_d;
            mask_q <= mask_d;
        end
    end
    assign irq_o = |(status_q & mask_q);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sys_uv_off_a: assert property (fs.system_rail_uv |=> unit_off_o)
        else $error("rail undervoltage did not shut the unit down");
    sys_uv_hold_a: assert property (sysuv_q && !fs.system_rail_uv && fs.channel_group_enable_pin
        && !fs.system_rail_ok |=> sysuv_q)
        else $error("rail undervoltage released early");
    main_ov_delay_a: assert property ($rose(ovm_q) |-> !unit_q [*3])
        else $error("overvoltage shut down without delay");
    cl_blank_a: assert property (fs.cur_limit[2] |=> ch_off_o[2])
        else $error("current limit did not blank the switches");
    ol_gap_clear_a: assert property (!qual[pfs_pkg::CNT_OL0 + 1] |=> cnt_q[pfs_pkg::CNT_OL0 + 1] == '0)
        else $error("overload counter kept counting over a clean cycle");
    unit_hold_a: assert property (unit_q && !por && !en_low |=> unit_q)
        else $error("unit shutdown released without reset or enable low");
    fb_uv_latch_a: assert property (fs.fb_uv[3] && fs.ss_done[3] |=> fbl_q[3] && ch_off_o[3])
        else $error("feedback undervoltage not latched");
    fb_uv_ss_a: assert property (!fs.ss_done[3] && !fbl_q[3] |=> !fbl_q[3])
        else $error("feedback undervoltage checked during soft-start");
    pre_uv_a: assert property (fs.precharge_done && fs.fb_uv[pfs_pkg::BOOST_CH] |=> ch_off_o[pfs_pkg::BOOST_CH])
        else $error("pre-charge undervoltage did not turn the boost off");
    led_only_a: assert property (led_hit && !unit_d && !sysuv_d && !therm_d
        && blank_d == '0 && fbl_d == '0 |=> led_off_o && ch_off_o == '0)
        else $error("led overvoltage not confined to its channel");
    led_hold_a: assert property (led_q && !por && !en_low |=> led_q)
        else $error("led shutdown released without reset or enable low");
    therm_stop_a: assert property (fs.temp_hot |=> stop_switching_o && ch_off_o == '1)
        else $error("over-temperature did not stop switching");

    // bus, status and release checks
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge lasted more than one cycle");
    ack_wait_a: assert property (req && !wb_ack_o |=> wb_ack_o)
        else $error("acknowledge missing after one wait state");
    status_set_a: assert property (ev[pfs_pkg::EV_UNIT_OFF] |=> status_q[pfs_pkg::EV_UNIT_OFF])
        else $error("shutdown event not recorded in status");
    status_hold_a: assert property (status_q[pfs_pkg::EV_SYS_UV] && !w1c[pfs_pkg::EV_SYS_UV]
        |=> status_q[pfs_pkg::EV_SYS_UV])
        else $error("status bit lost without a clear");
    status_clear_a: assert property (w1c[pfs_pkg::EV_SYS_UV] && !ev[pfs_pkg::EV_SYS_UV]
        |=> !status_q[pfs_pkg::EV_SYS_UV])
        else $error("status bit not cleared by a written one");
    sys_uv_release_a: assert property (fs.system_rail_ok && !fs.system_rail_uv |=> !sysuv_q)
        else $error("rail undervoltage not released on recovery");
    ovm_clear_a: assert property (fs.main_sense_low && !fs.main_sense_high |=> !ovm_q)
        else $error("overvoltage condition did not clear itself");
    blank_release_a: assert property (tick_rise && !fs.cur_limit[2] |=> !blank_q[2])
        else $error("current-limit blanking outlived its switching cycle");
    cl_count_a: assert property (qual[pfs_pkg::CNT_CL0 + 2] && cnt_q[pfs_pkg::CNT_CL0 + 2] != CNT_LAST
        |=> cnt_q[pfs_pkg::CNT_CL0 + 2] == $past(cnt_q[pfs_pkg::CNT_CL0 + 2]) + 1'b1)
        else $error("current-limit delay counter did not advance");
    unit_release_a: assert property (en_low && !(|done) |=> !unit_q)
        else $error("unit shutdown not released by enable low");
    boost_ss_a: assert property (!fs.ss_done[pfs_pkg::BOOST_CH] |=> cnt_q[pfs_pkg::CNT_BOOST_UV] == '0)
        else $error("boost output undervoltage counted during soft-start");
    boost_delay_a: assert property ($rose(qual[pfs_pkg::CNT_BOOST_UV]) && !unit_q |-> !unit_q [*3])
        else $error("boost output undervoltage shut down without delay");
    led_level_a: assert property (level_sel && !fs.led_ov_high && !led_q |=> !led_q)
        else $error("low led threshold used while high level selected");
    led_release_a: assert property (por && !led_hit |=> !led_q)
        else $error("led shutdown not released by power-on reset");
    led_field_clr_a: assert property (por |=> ctrl_q[pfs_pkg::CTRL_LED_LSB +: pfs_pkg::LED_FIELD_W] == '0)
        else $error("power-on reset left the led enable field set");
    therm_hold_a: assert property (therm_q && !fs.temp_cool |=> therm_q)
        else $error("thermal stop released before cooling");
    therm_release_a: assert property (fs.temp_cool && !fs.temp_hot |=> !stop_switching_o)
        else $error("thermal stop not released after cooling");
endmodule : pfs_supervisor
`default_nettype wire

// [verification/tb_pfs_supervisor.sv]
// self-checking bench of the power-unit fault supervisor
`timescale 1ns/10ps
`default_nettype none
module tb_pfs_supervisor;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    localparam int FC = 40;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [31:0] dat = 32'h0;
    logic [31:0] rdat;
    logic ack;
    pfs_pkg::pfs_flags_t flags;
    logic unit_off;
    logic [pfs_pkg::NCH-1:0] ch_off;
    logic led_off;
    logic stop_sw;
    logic irq;
    logic [15:0] rnd = 16'h000D;
    logic [31:0] exp_q[$];
    logic [31:0] msk_q[$];
    int miscompares = 0;
    int cmp_count = 0;

    pfs_supervisor #(.FAULT_CYCLES(FC)) DUT (.mclk(mclk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .flags_i(flags), .unit_off_o(unit_off), .ch_off_o(ch_off), .led_off_o(led_off),
        .stop_switching_o(stop_sw), .irq_o(irq));

    // clock and switching-cycle tick, rising every 8 clocks
    always #12.5 mclk = ~mclk;
    always begin
        repeat (4) @(posedge mclk);
        flags.cycle_tick <= ~flags.cycle_tick;
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp

    // fault outputs as {irq, unit, ch[4:0], led, stop}
    task automatic chk(input logic [8:0] e);
        repeat (5) @(posedge mclk);
        cmp("outputs", {23'h0, e}, {23'h0, irq, unit_off, ch_off, led_off, stop_sw});
    endtask : chk

    // one classic cycle; a read notes its expected value
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [31:0] m);
        int n;
        n = 0;
        @(posedge mclk);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        if (!w) begin
            exp_q.push_back(d & m);
            msk_q.push_back(m);
        end
        do begin
            @(posedge mclk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) miscompares++;
        cyc <= 1'b0;
        we <= 1'b0;
    endtask : wb

    // pulse the enable pin low or the power-on flag high
    task automatic rel(input logic por);
        @(posedge mclk);
        if (por) flags.main_supply_domain_por <= 1'b1;
        else flags.channel_group_enable_pin <= 1'b0;
        repeat (4) @(posedge mclk);
        flags.main_supply_domain_por <= 1'b0;
        flags.channel_group_enable_pin <= 1'b1;
    endtask : rel

    task automatic print_verdict();
        if (miscompares == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : print_verdict

    // read watcher: takes the oldest note at each read acknowledge
    always @(posedge mclk) begin
        if (ack === 1'b1 && cyc && !we && exp_q.size() > 0) begin
            cmp("read", exp_q.pop_front(), rdat & msk_q.pop_front());
        end
    end

    // watchdog
    initial begin
        repeat (10000) @(posedge mclk);
        miscompares++;
        print_verdict();
    end

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        flags = '0;
        flags.channel_group_enable_pin = 1'b1;
        flags.system_rail_ok = 1'b1;
        flags.main_sense_low = 1'b1;
        flags.temp_cool = 1'b1;
        repeat (10) @(posedge mclk);
        reset_n <= 1'b1;
        // reset values, state is read-only
        wb(1'b1, 4'hC, 32'hFFFFFFFF, 32'h0);
        for (int i = 0; i < 4; i++) wb(1'b0, 4'(i * 4), 32'h0, 32'hFFFFFFFF);
        // rail undervoltage latches, holds, releases on recovery or pin
        @(posedge mclk);
        flags.system_rail_uv <= 1'b1;
        flags.system_rail_ok <= 1'b0;
        chk(9'h0FE);
        flags.system_rail_uv <= 1'b0;
        chk(9'h0FE);
        flags.system_rail_ok <= 1'b1;
        chk(9'h000);
        flags.system_rail_uv <= 1'b1;
        flags.system_rail_ok <= 1'b0;
        chk(9'h0FE);
        flags.system_rail_uv <= 1'b0;
        rel(1'b0);
        chk(9'h000);
        flags.system_rail_ok <= 1'b1;
        // sticky status, mask and level interrupt
        wb(1'b0, 4'h4, 32'h1, 32'h1);
        wb(1'b1, 4'h8, 32'h1, 32'h0);
        chk(9'h100);
        wb(1'b1, 4'h4, 32'h1, 32'h0);
        chk(9'h000);
        wb(1'b0, 4'h4, 32'h0, 32'h1);
        rnd = lfsr(rnd);
        wb(1'b1, 4'h8, {rnd, rnd}, 32'h0);
        wb(1'b0, 4'h8, {rnd, rnd}, 32'h3F);
        wb(1'b1, 4'h8, 32'h0, 32'h0);
        // main-supply overvoltage: delayed shutdown, self-clearing condition
        @(posedge mclk);
        flags.main_sense_high <= 1'b1;
        flags.main_sense_low <= 1'b0;
        chk(9'h000);
        repeat (FC - 14) @(posedge mclk);
        chk(9'h000);
        repeat (8) @(posedge mclk);
        chk(9'h0FE);
        flags.main_sense_high <= 1'b0;
        flags.main_sense_low <= 1'b1;
        chk(9'h0FE);
        wb(1'b0, 4'hC, 32'h4, 32'h6);
        rel(1'b1);
        chk(9'h000);
        // current limit blanks until next cycle, persists to shutdown
        flags.cur_limit[2] <= 1'b1;
        chk(9'h010);
        flags.cur_limit[2] <= 1'b0;
        repeat (10) @(posedge mclk);
        chk(9'h000);
        flags.cur_limit[2] <= 1'b1;
        repeat (FC + 30) @(posedge mclk);
        chk(9'h0FE);
        flags.cur_limit[2] <= 1'b0;
        // let the last limited cycle age out so the expired counter stops re-setting the latch
        repeat (24) @(posedge mclk);
        rel(1'b0);
        repeat (10) @(posedge mclk);
        chk(9'h000);
        // overload with a clean cycle in between never shuts down
        for (int i = 0; i < 6; i++) begin
            flags.overload_flag[1] <= 1'b1;
            repeat (12) @(posedge mclk);
            flags.overload_flag[1] <= 1'b0;
            repeat (17) @(posedge mclk);
        end
        chk(9'h000);
        flags.overload_flag[1] <= 1'b1;
        repeat (FC + 40) @(posedge mclk);
        chk(9'h0FE);
        flags.overload_flag[1] <= 1'b0;
        repeat (24) @(posedge mclk);
        rel(1'b0);
        chk(9'h000);
        // feedback undervoltage counts only after soft-start, or after pre-charge on the boost, latches
        flags.fb_uv[3] <= 1'b1;
        chk(9'h000);
        flags.ss_done[3] <= 1'b1;
        chk(9'h020);
        flags.fb_uv[3] <= 1'b0;
        chk(9'h020);
        rel(1'b1);
        chk(9'h000);
        flags.precharge_done <= 1'b1;
        flags.fb_uv[0] <= 1'b1;
        chk(9'h004);
        flags.fb_uv[0] <= 1'b0;
        rel(1'b0);
        chk(9'h000);
        // step-up output undervoltage only after soft-start, delayed
        flags.boost_out_uv <= 1'b1;
        repeat (FC + 20) @(posedge mclk);
        chk(9'h000);
        flags.ss_done[0] <= 1'b1;
        chk(9'h000);
        repeat (FC + 10) @(posedge mclk);
        chk(9'h0FE);
        flags.boost_out_uv <= 1'b0;
        rel(1'b0);
        chk(9'h000);
        // LED overvoltage level select and LED-only shutdown
        flags.led_ov_low <= 1'b1;
        chk(9'h002);
        flags.led_ov_low <= 1'b0;
        rel(1'b0);
        wb(1'b1, 4'h0, 32'h1, 32'h0);
        flags.led_ov_low <= 1'b1;
        chk(9'h000);
        flags.led_ov_high <= 1'b1;
        chk(9'h002);
        // release by power-on flag also clears the LED field
        flags.led_ov_low <= 1'b0;
        flags.led_ov_high <= 1'b0;
        rnd = lfsr(rnd);
        wb(1'b1, 4'h0, {rnd, rnd} | 32'h0100, 32'h0);
        wb(1'b0, 4'h0, {rnd, rnd} | 32'h0100, 32'h1F01);
        wb(1'b0, 4'h2, 32'h0, 32'hFFFFFFFF);
        rel(1'b1);
        chk(9'h000);
        wb(1'b0, 4'h0, 32'h0, 32'h1F00);
        // thermal stop until cooled
        flags.temp_hot <= 1'b1;
        flags.temp_cool <= 1'b0;
        chk(9'h07F);
        flags.temp_hot <= 1'b0;
        chk(9'h07F);
        flags.temp_cool <= 1'b1;
        chk(9'h000);
        repeat (4) @(posedge mclk);
        print_verdict();
    end
endmodule : tb_pfs_supervisor
`default_nettype wire
